// *** src/rpi_pkg.sv ***
// Constants, carrier types and field layout of the receive-port interrupt status block.
// Assumes a single device clock and a register port that the I2C slave front end drives.
//
// Behaviour
// - One register copy per port except port select, chosen by select
// - Low bit 6: line length change, two-read clears
// - Low bit 5: line count change, two-read clears
// - Low bit 4: buffer overflow, two-read clears
// - Low bit 3: camera receiver error, its read clears
// - Low bit 2: parity error, one-read clears
// - Low bit 1: port valid change, one-read clears
// - Low bit 0: lock change, one-read clears
// - Low status read-only, resets zero, bit 7 zero
// - GPIO status bits 7:4 event flags, read clears
// - GPIO status bits 3:0 live values, no side effect
// - Control odd bits enable falling-edge events
// - Control even bits enable rising-edge events
// - Edge enables read-write, reset to zero
// - High bit 4 summary cleared by GPIO status read
// - Port interrupt only where low enable set
package rpi_pkg;

  localparam int NPORT = 2;
  localparam int NGPIO = 4;
  localparam int NLOW  = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PORT_SEL = 8'h4C;
  localparam logic [7:0] OFF_EN_LOW   = 8'hD9;
  localparam logic [7:0] OFF_ISR_HI   = 8'hDA;
  localparam logic [7:0] OFF_ISR_LO   = 8'hDB;
  localparam logic [7:0] OFF_GPIO_STS = 8'hDC;
  localparam logic [7:0] OFF_GPIO_ICR = 8'hDD;

  // ----------------------------------------------------------------
  // Field positions, clear masks and reset values
  // ----------------------------------------------------------------
  localparam int HI_GPIO_SUM_BIT = 4;
  localparam int GPIO_FLAG_LSB   = 4;
  localparam int GPIO_VAL_LSB    = 0;
  localparam int PSEL_BIT        = 0;

  localparam logic [6:0] CLR_TWO_MASK = 7'h70;
  localparam logic [6:0] CLR_CSI_MASK = 7'h08;
  localparam logic [6:0] CLR_ONE_MASK = 7'h07;

  localparam logic [7:0] EN_LOW_RST = 8'h00;
  localparam logic [7:0] ICR_RST    = 8'h00;
  localparam logic       PSEL_RST   = 1'b0;
  localparam logic [7:0] RDATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Member order gives bit 6 down to bit 0 of the low status register
  typedef struct packed {
    logic line_length_changed;
    logic line_count_changed;
    logic rx_buffer_overflow;
    logic camera_serial_rx_error;
    logic link_parity_error;
    logic port_valid_change;
    logic lock_change;
  } rpi_evt_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rpi_req_s;

  // Reads of the source status registers, decoded elsewhere
  typedef struct packed {
    logic port_status_one_rd;
    logic port_status_two_rd;
    logic camera_serial_rx_error_status_rd;
  } rpi_clr_s;

endpackage

// *** src/rpi_flag_bank.sv ***
// Bank of sticky status flags with per-bit set and clear.
// Assumes set and clear are one-cycle strobes on ref_clk.
`timescale 1ns/1ps
module rpi_flag_bank #(
  parameter int W = 7
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } rpi_fb_state_s;

  rpi_fb_state_s st_r;
  rpi_fb_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Set is applied after clear so an event in the clearing cycle is kept
    st_nxt.flags = (st_r.flags & ~clr) | set;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule

// *** src/rpi_gpio_edge.sv ***
// Forward-channel GPIO edge detector for one receive port.
// Assumes gpio_in is synchronous to ref_clk.
`timescale 1ns/1ps
module rpi_gpio_edge (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic [rpi_pkg::NGPIO-1:0] gpio_in,
  input  wire logic [rpi_pkg::NGPIO-1:0] rise_en,
  input  wire logic [rpi_pkg::NGPIO-1:0] fall_en,
  input  wire logic                     clr_rd,
  output logic      [rpi_pkg::NGPIO-1:0] value,
  output logic      [rpi_pkg::NGPIO-1:0] flags,
  output logic                          summary
);

  typedef struct packed {
    logic [rpi_pkg::NGPIO-1:0] prev;
    logic [rpi_pkg::NGPIO-1:0] flags;
    logic                      summary;
  } rpi_ge_state_s;

  rpi_ge_state_s             st_r;
  rpi_ge_state_s             st_nxt;
  logic [rpi_pkg::NGPIO-1:0] hit;

  always_comb begin
    st_nxt = st_r;
    hit = (gpio_in & ~st_r.prev & rise_en)
        | (~gpio_in & st_r.prev & fall_en);
    st_nxt.prev = gpio_in;
    st_nxt.flags = (clr_rd ? '0 : st_r.flags) | hit;
    st_nxt.summary = (clr_rd ? 1'b0 : st_r.summary) | (|hit);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Live level, not the edge history, so a read shows the present value
  assign value   = gpio_in;
  assign flags   = st_r.flags;
  assign summary = st_r.summary;

endmodule

// *** src/rpi_rx_port_irq.sv ***
// Per-receive-port interrupt status and forward-channel GPIO event registers.
// Assumes an I2C slave front end presents one-cycle register read and write
// strobes, and that reads of the source status registers arrive as strobes.
`timescale 1ns/1ps
module rpi_rx_port_irq (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst,
  input  wire logic                                 ce,
  input  wire rpi_pkg::rpi_req_s                    req,
  input  wire rpi_pkg::rpi_clr_s                    src_rd,
  input  wire rpi_pkg::rpi_evt_s [rpi_pkg::NPORT-1:0] evt,
  input  wire logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] fwd_gpio,
  output logic      [7:0]                           rdata,
  output logic                                      rd_valid,
  output logic                                      port_sel,
  output logic      [rpi_pkg::NPORT-1:0]            port_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                          sel;
    logic [rpi_pkg::NPORT-1:0][7:0] en_low;
    logic [rpi_pkg::NPORT-1:0][7:0] icr;
    logic [7:0]                    rdata;
    logic                          rd_valid;
  } rpi_top_state_s;

  rpi_top_state_s st_r;
  rpi_top_state_s st_nxt;

  // Flags and live values from the per-port copies
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NLOW-1:0]  low_flags;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NLOW-1:0]  low_set;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NLOW-1:0]  low_clr;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] g_val;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] g_flags;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] g_rise_en;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] g_fall_en;
  logic [rpi_pkg::NPORT-1:0]                    g_sum;
  logic [rpi_pkg::NPORT-1:0]                    g_clr;
  logic [rpi_pkg::NLOW-1:0]                     sel_clr_mask;
  logic [rpi_pkg::NPORT-1:0]                    sel_onehot;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Pack one port's view of a register at a given offset
  function automatic logic [7:0] view(
    input logic [7:0]                a,
    input logic [rpi_pkg::NLOW-1:0]  lf,
    input logic [rpi_pkg::NGPIO-1:0] gf,
    input logic [rpi_pkg::NGPIO-1:0] gv,
    input logic                      gs,
    input logic [7:0]                en,
    input logic [7:0]                ic
  );
    logic [7:0] v;
    v = 8'h00;
    if (hit(a, rpi_pkg::OFF_ISR_LO)) begin
      v = {1'b0, lf};
    end else if (hit(a, rpi_pkg::OFF_ISR_HI)) begin
      v[rpi_pkg::HI_GPIO_SUM_BIT] = gs;
    end else if (hit(a, rpi_pkg::OFF_GPIO_STS)) begin
      v = {gf, gv};
    end else if (hit(a, rpi_pkg::OFF_GPIO_ICR)) begin
      v = ic;
    end else if (hit(a, rpi_pkg::OFF_EN_LOW)) begin
      v = en;
    end
    view = v;
  endfunction

  // ----------------------------------------------------------------
  // Clear decoding shared by all ports
  // ----------------------------------------------------------------
  always_comb begin
    sel_clr_mask = '0;
    if (src_rd.port_status_two_rd) begin
      sel_clr_mask = sel_clr_mask | rpi_pkg::CLR_TWO_MASK;
    end
    if (src_rd.camera_serial_rx_error_status_rd) begin
      sel_clr_mask = sel_clr_mask | rpi_pkg::CLR_CSI_MASK;
    end
    if (src_rd.port_status_one_rd) begin
      sel_clr_mask = sel_clr_mask | rpi_pkg::CLR_ONE_MASK;
    end
  end

  // Only the page chosen by the select reaches the read side effects
  assign sel_onehot = rpi_pkg::NPORT'(1) << st_r.sel;

  // ----------------------------------------------------------------
  // Per-port copies
  // ----------------------------------------------------------------
  genvar p;
  genvar g;
  generate
    for (p = 0; p < rpi_pkg::NPORT; p++) begin : g_port
      assign low_set[p] = evt[p];
      assign low_clr[p] = sel_onehot[p] ? sel_clr_mask : '0;
      // Returned reads only: a write to the status offset clears nothing,
      // and a write beside a read wins, so that read returns nothing
      assign g_clr[p] = sel_onehot[p] & ce & req.rd & ~req.wr
                      & hit(req.addr, rpi_pkg::OFF_GPIO_STS);

      for (g = 0; g < rpi_pkg::NGPIO; g++) begin : g_bit
        assign g_rise_en[p][g] = st_r.icr[p][2*g];
        assign g_fall_en[p][g] = st_r.icr[p][2*g+1];
      end

      rpi_flag_bank #(
        .W (rpi_pkg::NLOW)
      ) u_low (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .set     (low_set[p]),
        .clr     (low_clr[p]),
        .flags   (low_flags[p])
      );

      rpi_gpio_edge u_gpio (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .gpio_in (fwd_gpio[p]),
        .rise_en (g_rise_en[p]),
        .fall_en (g_fall_en[p]),
        .clr_rd  (g_clr[p]),
        .value   (g_val[p]),
        .flags   (g_flags[p]),
        .summary (g_sum[p])
      );

      // Masked low conditions form the port interrupt
      assign port_irq[p] = |(low_flags[p] & st_r.en_low[p][rpi_pkg::NLOW-1:0]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes and read capture
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    if (req.wr) begin
      if (hit(req.addr, rpi_pkg::OFF_PORT_SEL)) begin
        st_nxt.sel = req.wdata[rpi_pkg::PSEL_BIT];
      end else if (hit(req.addr, rpi_pkg::OFF_EN_LOW)) begin
        st_nxt.en_low[st_r.sel] = req.wdata;
      end else if (hit(req.addr, rpi_pkg::OFF_GPIO_ICR)) begin
        st_nxt.icr[st_r.sel] = req.wdata;
      end
      // Status offsets are read-only; writes there fall through untouched
    end else if (req.rd) begin
      st_nxt.rd_valid = 1'b1;
      if (hit(req.addr, rpi_pkg::OFF_PORT_SEL)) begin
        st_nxt.rdata = {7'h00, st_r.sel};
      end else begin
        // Data is the value before this read's own clear takes effect
        st_nxt.rdata = view(req.addr, low_flags[st_r.sel], g_flags[st_r.sel],
                            g_val[st_r.sel], g_sum[st_r.sel],
                            st_r.en_low[st_r.sel], st_r.icr[st_r.sel]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r.sel      <= rpi_pkg::PSEL_RST;
      st_r.en_low   <= {rpi_pkg::NPORT{rpi_pkg::EN_LOW_RST}};
      st_r.icr      <= {rpi_pkg::NPORT{rpi_pkg::ICR_RST}};
      st_r.rdata    <= rpi_pkg::RDATA_RST;
      st_r.rd_valid <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rdata    = st_r.rdata;
  assign rd_valid = st_r.rd_valid;
  assign port_sel = st_r.sel;

endmodule

// *** bench/rpi_rx_port_irq_monitor.sv ***
// Port checks for the receive-port interrupt block.
// Assumes one clock, synchronous reset, bound onto rpi_rx_port_irq.
`timescale 1ns/1ps
module rpi_rx_port_irq_monitor (
  input wire logic                                          ref_clk,
  input wire logic                                          rst,
  input wire logic                                          ce,
  input wire rpi_pkg::rpi_req_s                             req,
  input wire rpi_pkg::rpi_clr_s                             src_rd,
  input wire rpi_pkg::rpi_evt_s [rpi_pkg::NPORT-1:0]        evt,
  input wire logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] fwd_gpio,
  input wire logic [7:0]                                    rdata,
  input wire logic                                          rd_valid,
  input wire logic                                          port_sel,
  input wire logic [rpi_pkg::NPORT-1:0]                     port_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_at(logic [7:0] a);
    ce && req.rd && !req.wr && req.addr == a;
  endsequence
  // GPIO steady and edge history taken last cycle, so no fresh edge can refill the flags
  sequence rd_dc_quiet;
    rd_at(8'hDC) ##0 $stable(fwd_gpio) ##0 $past(ce);
  endsequence
  rd_answer_a: assert property (ce && req.rd && !req.wr |=> rd_valid)
    else $error("read not answered");
  no_spurious_a: assert property (rd_valid |-> $past(ce && req.rd && !req.wr))
    else $error("answer without read");
  sel_write_a: assert property (ce && req.wr && req.addr == 8'h4C
    |=> port_sel == $past(req.wdata[0])) else $error("port select not written");
  sel_hold_a: assert property (!(ce && req.wr && req.addr == 8'h4C)
    |=> $stable(port_sel)) else $error("port select moved");
  low_rsvd_a: assert property (rd_at(8'hDB) |=> !rdata[7])
    else $error("low status bit 7 set");
  hi_rsvd_a: assert property (rd_at(8'hDA)
    |=> rdata[7:5] == 3'h0 && rdata[3:0] == 4'h0) else $error("high status spare bits");
  gpio_live_a: assert property (rd_at(8'hDC)
    |=> rdata[3:0] == $past(fwd_gpio[port_sel])) else $error("gpio value wrong");
  gpio_clear_a: assert property (rd_dc_quiet ##1 rd_dc_quiet
    |=> rdata[7:4] == 4'h0) else $error("gpio flags not cleared");
endmodule
bind rpi_rx_port_irq rpi_rx_port_irq_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .ce(ce),
  .req(req), .src_rd(src_rd), .evt(evt), .fwd_gpio(fwd_gpio), .rdata(rdata),
  .rd_valid(rd_valid), .port_sel(port_sel), .port_irq(port_irq));

// *** bench/rpi_host_model.sv ***
// Register host: random reads, writes and source-status clear strobes.
// Assumes quiet rises two edges before reset and falls with it.
`timescale 1ns/1ps
module rpi_host_model (
  input  wire logic   ref_clk,
  input  wire logic   quiet,
  output rpi_pkg::rpi_req_s req,
  output rpi_pkg::rpi_clr_s src_rd,
  output logic        ce
);
  localparam logic [7:0] AMAP [7] = '{8'h4C, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'h10};
  initial begin
    req = '0;
    src_rd = '0;
    ce = 1'b1;
  end
  always @(posedge ref_clk) begin
    req.addr  <= AMAP[$urandom_range(6)];
    req.wdata <= 8'($urandom);
    req.wr    <= !quiet && $urandom_range(5) == 0;
    req.rd    <= !quiet && $urandom_range(2) == 0;
    src_rd    <= quiet ? '0 : 3'($urandom) & 3'($urandom) & 3'($urandom);
    // Stall only with no answer pending; a frozen handshake is left open
    ce        <= quiet || req.rd || $urandom_range(7) != 0;
  end
endmodule

// *** bench/test_rx_port_interrupt_status.sv ***
// Random traffic against a reference model of the interrupt registers.
// Assumes the host model and the bound port monitor.
`timescale 1ns/1ps
module test_rx_port_interrupt_status;
  logic                                          ref_clk, rst, hold, ce, rd_valid, port_sel;
  rpi_pkg::rpi_req_s                             req;
  rpi_pkg::rpi_clr_s                             src_rd;
  rpi_pkg::rpi_evt_s [rpi_pkg::NPORT-1:0]        evt;
  logic [rpi_pkg::NPORT-1:0][rpi_pkg::NGPIO-1:0] fwd_gpio;
  logic [7:0]                                    rdata;
  logic [1:0]                                    port_irq;
  int failures, tests_run, n, sel, e_rd, e_vld;
  int lowf[2], gfl[2], en[2], ic[2], prv[2], sum[2];

  rpi_host_model i_rpi_host_model (.ref_clk(ref_clk), .quiet(hold), .req(req),
    .src_rd(src_rd), .ce(ce));
  rpi_rx_port_irq i_rpi_rx_port_irq (.ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req),
    .src_rd(src_rd), .evt(evt), .fwd_gpio(fwd_gpio), .rdata(rdata), .rd_valid(rd_valid),
    .port_sel(port_sel), .port_irq(port_irq));

  task automatic chk(string what, int exp, logic [7:0] got);
    tests_run++;
    if (8'(exp) !== got) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, 8'(exp), got);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus and reference model
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    void'($urandom(34682));
    {rst, hold, n, failures, tests_run} = '0;
    {rst, hold} = 2'h3;
    evt = '0;
    fwd_gpio = '0;
    repeat (6000) @(posedge ref_clk);
    conclude();
  end
  always @(posedge ref_clk) begin
    n <= n + 1;
    // Second reset mid-run; the host goes quiet two edges early
    rst  <= n < 5 || (n >= 3000 && n < 3003);
    hold <= n < 5 || (n >= 2998 && n < 3003);
    foreach (evt[p]) evt[p] <= 7'($urandom) & 7'($urandom) & 7'($urandom);
    if ($urandom_range(3) == 0) fwd_gpio <= 8'($urandom);
    if (n == 20000) begin
      failures++;
      conclude();
    end
  end
  always @(posedge ref_clk) begin
    int clr, set, g;
    if (rst) begin
      foreach (lowf[p]) {lowf[p], gfl[p], en[p], ic[p], prv[p], sum[p]} = '0;
      {sel, e_rd, e_vld} = '0;
    end else if (ce) begin
      e_vld = req.rd && !req.wr;
      if (e_vld) case (req.addr)
        8'h4C: e_rd = sel;
        8'hD9: e_rd = en[sel];
        8'hDA: e_rd = sum[sel] << 4;
        8'hDB: e_rd = lowf[sel];
        8'hDC: e_rd = gfl[sel] << 4 | fwd_gpio[sel];
        8'hDD: e_rd = ic[sel];
        default: e_rd = 0;
      endcase
      for (int p = 0; p < 2; p++) begin
        clr = p != sel ? 0 : (src_rd.port_status_two_rd ? 'h70 : 0) |
          (src_rd.camera_serial_rx_error_status_rd ? 'h08 : 0) |
          (src_rd.port_status_one_rd ? 'h07 : 0);
        lowf[p] = lowf[p] & ~clr | evt[p];
        g = fwd_gpio[p];
        set = 0;
        for (int b = 0; b < 4; b++)
          if (g[b] != prv[p][b] && ic[p][2*b + !g[b]]) set |= 1 << b;
        clr = p == sel && e_vld && req.addr == 8'hDC;
        gfl[p] = clr ? set : gfl[p] | set;
        sum[p] = clr ? set != 0 : sum[p] | (set != 0);
        prv[p] = g;
      end
      if (req.wr) case (req.addr)
        8'h4C: sel = req.wdata[0];
        8'hD9: en[sel] = req.wdata;
        8'hDD: ic[sel] = req.wdata;
        default: ;
      endcase
    end else e_vld = 0;
  end
  always @(negedge ref_clk) begin
    chk("rd_valid", e_vld, rd_valid);
    if (e_vld) chk("rdata", e_rd, rdata);
    for (int p = 0; p < 2; p++) chk("port_irq", |(lowf[p] & en[p] & 'h7F), port_irq[p]);
  end
endmodule
